// >>> design/anm_regbank.sv
/*
  Auto-negotiation management register bank: control, status,
  advertisement, partner pages, expansion and next page transmit,
  plus the state machine variables that hang off them.
  Assumes the negotiation state machine and PCS on the same clock, and
  power_good and mgmt_absent as asynchronous pins.
*/
// Summary of operation
// RQ1 - Control bit 12 enables negotiation
// RQ2 - Control bit 15 write resets negotiation
// RQ3 - Control bit 9 write requests renegotiation
// RQ4 - Register 4 holds advertised base page
// RQ5 - Register 5 shows received partner base page
// RQ6 - Register 8 shows received partner next page
// RQ7 - Register 7 next page loads transmit word
// RQ8 - Write to register 7 sets loaded flag
// RQ9 - Page received needs both matches and storage
// RQ10 - Base page to 5, next page to 8
// RQ11 - Status bit 5 shows negotiation complete
// RQ12 - Expansion bit 2 shows next page ability
// RQ13 - Without management use fixed advertisement
// RQ14 - Qualified sync fails after timed loss
// RQ15 - Capture partner NP bit at acknowledge
// RQ16 - Power-on until power good, or low power
// RQ17 - Defaulted variables revert when not set
// RQ18 - Track the partner toggle bit
// RQ19 - Management reads page 8 before writing 7
// RQ20 - Link timer lasts ten milliseconds
// RQ21 - Expansion read clears page received
// RQ22 - Array element n is bit n minus 1
`timescale 1ns/1ps
`default_nettype none
module anm_regbank #(
  parameter int LINK_CYC = anm_pkg::LINK_TIMER_CYC
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rstn,
  // Management register port.
  input wire anm_pkg::anm_mgmt_req_s mgmt_req,
  output logic [15:0] mgmt_rdata,
  output logic mgmt_rvalid,
  // Asynchronous pins.
  input wire logic power_good,
  input wire logic mgmt_absent,
  // PCS and negotiation state machine.
  input wire logic sync_ok,
  input wire anm_pkg::anm_fsm_evt_s fsm_evt,
  output anm_pkg::anm_fsm_ctl_s fsm_ctl,
  output logic [15:0] tx_config_word,
  output logic qualified_sync_state,
  output logic negotiation_done
);

  // Pin synchronisers: bit 0 power good, bit 1 management absent.
  logic [1:0] pin_meta_q, pin_sync_q;

  // Control register state.
  logic ctrl_en_q, ctrl_loop_q, ctrl_lowpwr_q;
  logic reset_q, restart_q;

  // Page registers and flags.
  logic [15:0] adv_q, nptx_q, lpbase_q, lpnp_q, tx_q, rdata_q;
  logic page_rx_q, np_written_q, rvalid_q;
  logic ack_prev_q, np_at_ack_q, partner_np_q, toggle_q, resolve_q;

  // Address decode.
  wire logic sel_ctrl = (mgmt_req.addr == anm_pkg::REG_CTRL);
  wire logic sel_stat = (mgmt_req.addr == anm_pkg::REG_STAT);
  wire logic sel_adv = (mgmt_req.addr == anm_pkg::REG_ADV);
  wire logic sel_lpbase = (mgmt_req.addr == anm_pkg::REG_LPBASE);
  wire logic sel_exp = (mgmt_req.addr == anm_pkg::REG_EXP);
  wire logic sel_nptx = (mgmt_req.addr == anm_pkg::REG_NPTX);
  wire logic sel_lpnp = (mgmt_req.addr == anm_pkg::REG_LPNP);
  wire logic wr_ctrl = mgmt_req.wr && sel_ctrl;
  wire logic wr_adv = mgmt_req.wr && sel_adv;
  wire logic wr_nptx = mgmt_req.wr && sel_nptx;
  wire logic rd_exp = mgmt_req.rd && sel_exp;

  // A page counts only with both matches; the store happens alongside.
  wire logic page_ok = fsm_evt.page_stb && fsm_evt.ack_match &&
    fsm_evt.cons_match; // see RQ9
  wire logic store_base = page_ok && !fsm_evt.page_is_next; // see RQ10
  wire logic store_next = page_ok && fsm_evt.page_is_next; // see RQ10
  wire logic ack_rise = fsm_evt.ack_match && !ack_prev_q;
  wire logic rx_np = fsm_evt.rx_config[anm_pkg::CFG_NP_BIT];

  // Advertised page source: the fixed word when no manager is fitted.
  wire logic [15:0] adv_eff = pin_sync_q[1] ?
    anm_pkg::ADV_FIXED_VAL : adv_q; // see RQ13
  wire logic power_on = !pin_sync_q[0] || ctrl_lowpwr_q; // see RQ16

  // Status words; element n of each array sits at bit n-1.
  wire logic [15:0] ctrl_word = {reset_q, ctrl_loop_q, 1'b0, ctrl_en_q,
    ctrl_lowpwr_q, 1'b0, restart_q, 9'h000}; // see RQ22
  wire logic [15:0] stat_word = {10'h000, negotiation_done, 1'b0,
    1'b1, fsm_evt.xmit_data, 2'b00}; // see RQ11
  wire logic [15:0] exp_word = {13'h0000, anm_pkg::NP_ABLE_VAL,
    page_rx_q, 1'b0}; // see RQ12

  // Read multiplexer; unmapped indices read as zero.
  wire logic [15:0] rd_mux =
    sel_ctrl ? ctrl_word :
    sel_stat ? stat_word :
    sel_adv ? adv_q :
    sel_lpbase ? lpbase_q :
    sel_exp ? exp_word :
    sel_nptx ? nptx_q :
    sel_lpnp ? lpnp_q : 16'h0000;

  // Two flops before any logic sees the pins.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pin_meta_q <= 2'h0;
      pin_sync_q <= 2'h0;
    end else begin
      pin_meta_q <= {mgmt_absent, power_good};
      pin_sync_q <= pin_meta_q;
    end
  end

  // Control register; reset and restart are self-clearing pulses.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl_en_q <= anm_pkg::CTRL_EN_RST;
      ctrl_loop_q <= 1'b0;
      ctrl_lowpwr_q <= 1'b0;
      reset_q <= 1'b0;
      restart_q <= 1'b0;
    end else begin
      reset_q <= wr_ctrl &&
        mgmt_req.wdata[anm_pkg::CTRL_RESET_BIT]; // see RQ2
      restart_q <= wr_ctrl &&
        mgmt_req.wdata[anm_pkg::CTRL_RESTART_BIT]; // see RQ3
      if (wr_ctrl) begin
        ctrl_en_q <= mgmt_req.wdata[anm_pkg::CTRL_EN_BIT]; // see RQ1
        ctrl_loop_q <= mgmt_req.wdata[anm_pkg::CTRL_LOOP_BIT];
        ctrl_lowpwr_q <= mgmt_req.wdata[anm_pkg::CTRL_LOWPWR_BIT];
      end
    end
  end

  // Writable page registers; reserved advertisement bits stay zero.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      adv_q <= anm_pkg::ADV_RST_VAL;
      nptx_q <= anm_pkg::WORD_RST_VAL;
    end else begin
      if (wr_adv) begin
        adv_q <= mgmt_req.wdata & anm_pkg::ADV_WR_MASK; // see RQ4
      end
      if (wr_nptx) begin
        nptx_q <= mgmt_req.wdata; // see RQ7
      end
    end
  end

  // Partner pages are written only by received pages, never by writes.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lpbase_q <= anm_pkg::WORD_RST_VAL;
      lpnp_q <= anm_pkg::WORD_RST_VAL;
    end else begin
      if (store_base) begin
        lpbase_q <= fsm_evt.rx_config; // see RQ5
      end
      if (store_next) begin
        lpnp_q <= fsm_evt.rx_config; // see RQ6
      end
    end
  end

  // Sticky flags: a set in the clearing cycle wins, so none is lost.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      page_rx_q <= 1'b0;
      np_written_q <= 1'b0;
    end else begin
      page_rx_q <= page_ok ||
        (page_rx_q && !rd_exp && !reset_q); // see RQ9 see RQ21
      np_written_q <= wr_nptx ||
        (np_written_q && !fsm_evt.np_loaded_clr && !reset_q); // see RQ8
    end
  end

  // Transmit word: a pending next page load beats the base page.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tx_q <= anm_pkg::WORD_RST_VAL;
    end else if (fsm_evt.load_np) begin
      tx_q <= nptx_q; // see RQ7
    end else if (fsm_evt.load_adv) begin
      tx_q <= adv_eff; // see RQ4 see RQ13
    end
  end

  // Partner NP bit follows the value seen when acknowledge rose last.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ack_prev_q <= 1'b0;
      np_at_ack_q <= 1'b0;
      partner_np_q <= 1'b0;
      toggle_q <= 1'b0;
    end else begin
      ack_prev_q <= fsm_evt.ack_match;
      if (ack_rise) begin
        np_at_ack_q <= rx_np;
      end
      if (fsm_evt.enter_cmpl_ack) begin
        partner_np_q <= ack_rise ? rx_np : np_at_ack_q; // see RQ15
      end
      if (fsm_evt.toggle_upd) begin
        toggle_q <=
          fsm_evt.rx_config[anm_pkg::CFG_TOGGLE_BIT]; // see RQ18
      end
    end
  end

  // Priority resolution falls back to OFF in any cycle it is not set.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      resolve_q <= 1'b0;
    end else begin
      resolve_q <= fsm_evt.resolve_on; // see RQ17
    end
  end

  // Registered read data, valid the cycle after the read request.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 16'h0000;
      rvalid_q <= 1'b0;
      negotiation_done <= 1'b0;
    end else begin
      rvalid_q <= mgmt_req.rd;
      if (mgmt_req.rd) begin
        rdata_q <= rd_mux;
      end
      negotiation_done <= fsm_evt.an_complete && !reset_q; // see RQ11
    end
  end

  // Timed sync qualifier.
  anm_sync_qual #(
    .LINK_CYC(LINK_CYC)
  ) u_sync_qual (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .sync_ok(sync_ok),
    .qualified_sync_state(qualified_sync_state)
  );

  // Outputs toward the state machine, taken from registers except the constant next page ability and the gated advert page and power_on.
  assign mgmt_rdata = rdata_q;
  assign mgmt_rvalid = rvalid_q;
  assign tx_config_word = tx_q;
  assign fsm_ctl.negotiation_enabled = ctrl_en_q; // see RQ1
  assign fsm_ctl.negotiation_reset = reset_q; // see RQ2
  assign fsm_ctl.renegotiate_request = restart_q; // see RQ3
  assign fsm_ctl.internal_loop_select = ctrl_loop_q;
  assign fsm_ctl.local_advert_page = adv_eff;
  assign fsm_ctl.next_page_outgoing = nptx_q;
  assign fsm_ctl.next_page_written = np_written_q;
  assign fsm_ctl.next_page_capable = anm_pkg::NP_ABLE_VAL; // see RQ12
  assign fsm_ctl.page_arrived = page_rx_q;
  assign fsm_ctl.power_on = power_on;
  assign fsm_ctl.resolve_priority = resolve_q;
  assign fsm_ctl.toggle_rx = toggle_q;
  assign fsm_ctl.partner_np_captured = partner_np_q;

  page_set_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see RQ9
    page_ok |=> page_rx_q && (lpbase_q == $past(fsm_evt.rx_config) ||
      lpnp_q == $past(fsm_evt.rx_config)))
    else $error("page received without the page stored");

  page_clear_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see RQ21
    rd_exp && !page_ok |=> !page_rx_q && mgmt_rvalid)
    else $error("page received flag survived negotiation_expansion read");

  np_loaded_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see RQ8
    wr_nptx |=> np_written_q && nptx_q == $past(mgmt_req.wdata))
    else $error("next page write did not set the loaded flag");

  page_route_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see RQ10
    store_next |=> $stable(lpbase_q))
    else $error("next page overwrote the partner base page");

  restart_pulse_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see RQ3
    wr_ctrl && mgmt_req.wdata[anm_pkg::CTRL_RESTART_BIT]
      |=> restart_q ##1 (restart_q == $past(wr_ctrl &&
      mgmt_req.wdata[anm_pkg::CTRL_RESTART_BIT])))
    else $error("restart request is not a one-write pulse");

  enable_write_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see RQ1
    wr_ctrl |=> fsm_ctl.negotiation_enabled ==
      $past(mgmt_req.wdata[anm_pkg::CTRL_EN_BIT]))
    else $error("enable does not follow control bit 12");

  power_on_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see RQ16
    ctrl_lowpwr_q || !pin_sync_q[0] |-> fsm_ctl.power_on)
    else $error("power-on condition missing in low power");

  tx_load_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see RQ7
    fsm_evt.load_np |=> tx_config_word == $past(nptx_q))
    else $error("next page not loaded into transmit word");

  np_capture_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see RQ15
    fsm_evt.enter_cmpl_ack && !ack_rise |=>
      partner_np_q == $past(np_at_ack_q))
    else $error("partner next page bit not from acknowledge time");

  resolve_off_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see RQ17
    !fsm_evt.resolve_on |=> !fsm_ctl.resolve_priority)
    else $error("priority resolution held without request");

endmodule
`default_nettype wire

// >>> design/anm_pkg.sv
/*
  Shared constants and types for the auto-negotiation management map:
  register indices, bit positions, reset values, timing and carriers.
  Assumes a single 200 MHz system clock with a 5 ns period.
*/
package anm_pkg;

  // Register indices on the management register port.
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STAT = 5'h01;
  localparam logic [4:0] REG_ADV = 5'h04;
  localparam logic [4:0] REG_LPBASE = 5'h05;
  localparam logic [4:0] REG_EXP = 5'h06;
  localparam logic [4:0] REG_NPTX = 5'h07;
  localparam logic [4:0] REG_LPNP = 5'h08;

  // Control register fields.
  localparam int CTRL_RESET_BIT = 15;
  localparam int CTRL_LOOP_BIT = 14;
  localparam int CTRL_EN_BIT = 12;
  localparam int CTRL_LOWPWR_BIT = 11;
  localparam int CTRL_RESTART_BIT = 9;

  // Status and expansion register fields.
  localparam int STAT_DONE_BIT = 5;
  localparam int STAT_ABLE_BIT = 3;
  localparam int STAT_LINK_BIT = 2;
  localparam int EXP_NPABLE_BIT = 2;
  localparam int EXP_PAGERX_BIT = 1;

  // Configuration word fields.
  localparam int CFG_NP_BIT = 15;
  localparam int CFG_TOGGLE_BIT = 11;

  // Reset values and write masks.
  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic [15:0] ADV_RST_VAL = 16'h0060;
  localparam logic [15:0] ADV_FIXED_VAL = 16'h0060;
  localparam logic [15:0] ADV_WR_MASK = 16'hB1E0;
  localparam logic [15:0] WORD_RST_VAL = 16'h0000;
  localparam logic NP_ABLE_VAL = 1'b1;

  // Link timer: least time, rounded up to whole cycles.
  localparam int CLK_PERIOD_NS = 5;
  localparam int LINK_TIMER_NS = 10_000_000;
  localparam int LINK_TIMER_CYC =
    (LINK_TIMER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LT_CNT_W = 21;

  // One management register access request.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [15:0] wdata;
  } anm_mgmt_req_s;

  // Events and levels from the negotiation state machine and PCS.
  typedef struct packed {
    logic [15:0] rx_config;
    logic page_stb;
    logic page_is_next;
    logic ack_match;
    logic cons_match;
    logic np_loaded_clr;
    logic enter_cmpl_ack;
    logic toggle_upd;
    logic load_adv;
    logic load_np;
    logic resolve_on;
    logic an_complete;
    logic xmit_data;
  } anm_fsm_evt_s;

  // Control and status handed to the negotiation state machine.
  typedef struct packed {
    logic negotiation_enabled;
    logic negotiation_reset;
    logic renegotiate_request;
    logic internal_loop_select;
    logic [15:0] local_advert_page;
    logic [15:0] next_page_outgoing;
    logic next_page_written;
    logic next_page_capable;
    logic page_arrived;
    logic power_on;
    logic resolve_priority;
    logic toggle_rx;
    logic partner_np_captured;
  } anm_fsm_ctl_s;

  // Sync qualifier states, Gray coded along OK, WAIT, FAIL.
  typedef enum logic [1:0] {
    SQ_OK = 2'b00,
    SQ_WAIT = 2'b01,
    SQ_FAIL = 2'b11
  } anm_sq_state_e;

endpackage

// >>> design/anm_sync_qual.sv
/*
  Sync status qualifier: reports FAIL only after code-group sync has
  been lost for the whole link timer.
  Assumes sync_ok comes from PCS logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module anm_sync_qual #(
  parameter int LINK_CYC = anm_pkg::LINK_TIMER_CYC
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rstn,
  // Raw and qualified sync status.
  input wire logic sync_ok,
  output logic qualified_sync_state
);

  // Fail waits for the sample after LINK_CYC lost ones, so it is never early.
  localparam logic [anm_pkg::LT_CNT_W-1:0] LAST =
    anm_pkg::LT_CNT_W'(LINK_CYC);

  anm_pkg::anm_sq_state_e state_q, state_d;
  logic [anm_pkg::LT_CNT_W-1:0] cnt_q, cnt_d;

  // Count consecutive fail samples; any OK sample restarts the wait.
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    unique case (state_q)
      anm_pkg::SQ_OK: begin
        if (!sync_ok) begin
          state_d = anm_pkg::SQ_WAIT;
          cnt_d = anm_pkg::LT_CNT_W'(1);
        end
      end
      anm_pkg::SQ_WAIT: begin
        if (sync_ok) begin
          state_d = anm_pkg::SQ_OK;
        end else if (cnt_q >= LAST) begin
          state_d = anm_pkg::SQ_FAIL; // see RQ14 see RQ20
        end else begin
          cnt_d = cnt_q + anm_pkg::LT_CNT_W'(1);
        end
      end
      anm_pkg::SQ_FAIL: begin
        if (sync_ok) begin
          state_d = anm_pkg::SQ_OK;
        end
      end
      default: state_d = anm_pkg::SQ_OK;
    endcase
  end

  // State and counter registers.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q <= anm_pkg::SQ_OK;
      cnt_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // OK everywhere except the timed-out state.
  assign qualified_sync_state = (state_q != anm_pkg::SQ_FAIL); // see RQ14

  qual_fail_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see RQ14
    $rose(state_q == anm_pkg::SQ_FAIL) |-> cnt_q == LAST && !$past(sync_ok))
    else $error("qualified sync failed before the link timer ran out");

  qual_ok_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see RQ14
    sync_ok |=> qualified_sync_state)
    else $error("qualified sync not OK after raw sync returned");

endmodule
`default_nettype wire

// >>> test/anm_mgmt_model.sv
/*
  Management station model: issues register reads and writes.
  Assumes the bank takes requests on rising clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module anm_mgmt_model (
  // Clock.
  input wire logic clk_sys,
  // Register port.
  output var anm_pkg::anm_mgmt_req_s mgmt_req,
  input wire logic [15:0] mgmt_rdata,
  input wire logic mgmt_rvalid
);
  // Port idles from time zero.
  initial begin
    mgmt_req = '0;
  end

  // Released fields are scrambled so stale values are never trusted.
  task automatic idle();
    mgmt_req.wr = 1'b0;
    mgmt_req.rd = 1'b0;
    mgmt_req.addr = ~mgmt_req.addr;
    mgmt_req.wdata = ~mgmt_req.wdata;
  endtask

  // One write, held until the edge that takes it.
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    #1;
    mgmt_req.wr = 1'b1;
    mgmt_req.addr = a;
    mgmt_req.wdata = d;
    @(posedge clk_sys);
    #1;
    idle();
  endtask

  // One read; data and valid come one cycle after the request.
  task automatic rd(input logic [4:0] a, output logic [15:0] d,
                    output logic v);
    @(posedge clk_sys);
    #1;
    mgmt_req.rd = 1'b1;
    mgmt_req.addr = a;
    @(posedge clk_sys);
    #1;
    d = mgmt_rdata;
    v = mgmt_rvalid;
    idle();
  endtask

  // Read the partner next page first so it is not overlaid.
  task automatic np_send(input logic [15:0] d, output logic [15:0] lp);
    logic v;
    rd(anm_pkg::REG_LPNP, lp, v);
    wr(anm_pkg::REG_NPTX, d);
  endtask
endmodule
`default_nettype wire

// >>> test/anm_regbank_tb.sv
/*
  Self-checking bench for the negotiation register bank.
  Assumes the station model beside it and a short link timer.
*/
`timescale 1ns/1ps
`default_nettype none
module anm_regbank_tb;
  localparam int LC = 16;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic power_good = 1'b0;
  logic mgmt_absent = 1'b0;
  logic sync_ok = 1'b1;
  anm_pkg::anm_fsm_evt_s evt = '0;
  anm_pkg::anm_mgmt_req_s mgmt_req;
  logic [15:0] mgmt_rdata;
  logic mgmt_rvalid;
  anm_pkg::anm_fsm_ctl_s fsm_ctl;
  logic [15:0] tx_config_word;
  logic qualified_sync_state;
  logic negotiation_done;
  int error_cnt = 0;
  int cmp_count = 0;

  // Clock at 200 MHz.
  always #2.5 clk_sys = ~clk_sys;

  anm_regbank #(.LINK_CYC(LC)) i_dut (
    .clk_sys(clk_sys), .rstn(rstn), .mgmt_req(mgmt_req),
    .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid),
    .power_good(power_good), .mgmt_absent(mgmt_absent),
    .sync_ok(sync_ok), .fsm_evt(evt), .fsm_ctl(fsm_ctl),
    .tx_config_word(tx_config_word),
    .qualified_sync_state(qualified_sync_state),
    .negotiation_done(negotiation_done)
  );

  anm_mgmt_model i_mgmt (
    .clk_sys(clk_sys), .mgmt_req(mgmt_req),
    .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid)
  );

  task automatic chk(input string nm, input logic [15:0] exp,
                     input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Inputs change 1 ns after the edge, so outputs have settled.
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic rdc(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic v;
    i_mgmt.rd(a, d, v);
    chk("rvalid", 16'h0001, {15'h0000, v});
    chk($sformatf("reg%0d", a), exp, d);
  endtask

  task automatic t_reset();
    chk("power_on", 1'b1, fsm_ctl.power_on);
    power_good = 1'b1;
    tick(4);
    chk("power_on", 1'b0, fsm_ctl.power_on);
    rdc(anm_pkg::REG_CTRL, 16'h1000);
    rdc(anm_pkg::REG_STAT, 16'h0008);
    rdc(anm_pkg::REG_EXP, 16'h0004);
    rdc(anm_pkg::REG_ADV, 16'h0060);
    rdc(5'h02, 16'h0000);
    chk("np_able", 1'b1, fsm_ctl.next_page_capable);
    $display("test reset done");
  endtask

  task automatic t_ctrl();
    i_mgmt.wr(anm_pkg::REG_CTRL, 16'h4800);
    chk("enable", 1'b0, fsm_ctl.negotiation_enabled);
    chk("loop", 1'b1, fsm_ctl.internal_loop_select);
    chk("power_on", 1'b1, fsm_ctl.power_on);
    rdc(anm_pkg::REG_CTRL, 16'h4800);
    i_mgmt.wr(anm_pkg::REG_CTRL, 16'h9200);
    chk("reset", 1'b1, fsm_ctl.negotiation_reset);
    chk("restart", 1'b1, fsm_ctl.renegotiate_request);
    chk("enable", 1'b1, fsm_ctl.negotiation_enabled);
    tick(1);
    chk("reset", 1'b0, fsm_ctl.negotiation_reset);
    chk("restart", 1'b0, fsm_ctl.renegotiate_request);
    chk("power_on", 1'b0, fsm_ctl.power_on);
    $display("test control done");
  endtask

  task automatic t_adv();
    i_mgmt.wr(anm_pkg::REG_ADV, 16'hFFFF);
    rdc(anm_pkg::REG_ADV, 16'hB1E0);
    chk("adv", 16'hB1E0, fsm_ctl.local_advert_page);
    evt.load_adv = 1'b1;
    tick(1);
    evt.load_adv = 1'b0;
    chk("tx", 16'hB1E0, tx_config_word);
    mgmt_absent = 1'b1;
    tick(3);
    evt.load_adv = 1'b1;
    tick(1);
    evt.load_adv = 1'b0;
    chk("tx", anm_pkg::ADV_FIXED_VAL, tx_config_word);
    mgmt_absent = 1'b0;
    $display("test advert done");
  endtask

  task automatic t_page();
    evt.rx_config = 16'hA5C3;
    evt.cons_match = 1'b1;
    evt.page_stb = 1'b1;
    tick(1);
    chk("page", 1'b0, fsm_ctl.page_arrived);
    evt.ack_match = 1'b1;
    tick(1);
    evt.page_stb = 1'b0;
    chk("page", 1'b1, fsm_ctl.page_arrived);
    i_mgmt.wr(anm_pkg::REG_LPBASE, 16'h0000);
    rdc(anm_pkg::REG_LPBASE, 16'hA5C3);
    rdc(anm_pkg::REG_EXP, 16'h0006);
    rdc(anm_pkg::REG_EXP, 16'h0004);
    evt.rx_config = 16'h3C5A;
    evt.page_is_next = 1'b1;
    evt.page_stb = 1'b1;
    tick(1);
    evt.page_stb = 1'b0;
    evt.ack_match = 1'b0;
    rdc(anm_pkg::REG_LPNP, 16'h3C5A);
    rdc(anm_pkg::REG_LPBASE, 16'hA5C3);
    $display("test page done");
  endtask

  task automatic t_np();
    logic [15:0] lp;
    i_mgmt.np_send(16'h2801, lp);
    chk("lp_np", 16'h3C5A, lp);
    chk("np_written", 1'b1, fsm_ctl.next_page_written);
    chk("np_out", 16'h2801, fsm_ctl.next_page_outgoing);
    evt.np_loaded_clr = 1'b1;
    tick(1);
    evt.np_loaded_clr = 1'b0;
    chk("np_written", 1'b0, fsm_ctl.next_page_written);
    evt.load_np = 1'b1;
    tick(1);
    evt.load_np = 1'b0;
    chk("tx", 16'h2801, tx_config_word);
    $display("test next page done");
  endtask

  // Fail needs LC whole cycles of lost sync, so it shows one sample later.
  task automatic t_sync();
    sync_ok = 1'b0;
    tick(LC);
    chk("sync", 1'b1, qualified_sync_state);
    tick(1);
    chk("sync", 1'b0, qualified_sync_state);
    sync_ok = 1'b1;
    tick(1);
    chk("sync", 1'b1, qualified_sync_state);
    $display("test sync done");
  endtask

  task automatic t_misc();
    evt.rx_config = 16'h0800;
    evt.toggle_upd = 1'b1;
    tick(1);
    evt.toggle_upd = 1'b0;
    chk("toggle", 1'b1, fsm_ctl.toggle_rx);
    evt.rx_config = 16'h8000;
    evt.ack_match = 1'b1;
    tick(1);
    evt.rx_config = 16'h0000;
    evt.enter_cmpl_ack = 1'b1;
    tick(1);
    evt.enter_cmpl_ack = 1'b0;
    chk("partner_np_captured", 1'b1, fsm_ctl.partner_np_captured);
    evt.resolve_on = 1'b1;
    tick(1);
    evt.resolve_on = 1'b0;
    chk("resolve", 1'b1, fsm_ctl.resolve_priority);
    tick(1);
    chk("resolve", 1'b0, fsm_ctl.resolve_priority);
    evt.an_complete = 1'b1;
    evt.xmit_data = 1'b1;
    tick(1);
    chk("done", 1'b1, negotiation_done);
    rdc(anm_pkg::REG_STAT, 16'h002C);
    $display("test state vars done");
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Main sequence after a 16-cycle reset.
  initial begin
    repeat (16) @(posedge clk_sys);
    #1;
    rstn = 1'b1;
    t_reset();
    t_ctrl();
    t_adv();
    t_page();
    t_np();
    t_sync();
    t_misc();
    finish_test();
  end

  // Watchdog: the tests need about a hundred cycles, this allows 4000.
  initial begin
    #20000;
    error_cnt++;
    $display("ERROR watchdog expected end seen timeout");
    finish_test();
  end
endmodule
`default_nettype wire
